// ==== core/cursor_y_split_line_compare.v ====
// cursor vertical position and split-screen line compare with apb registers
// What this block does
// - row-skip field picks first shown cursor line
// - cursor vertical coordinate is top screen line
// - cursor y doubles as start-offset line compare
// - eleven-bit split line threshold field
// - threshold match restarts fetch address at zero
// - restart only while split enable is set
// - eleven-bit scanline counter compared against both
//
// Our own choice: the APB register port.
`timescale 1ns/10ps
`include "cursor_y_split_regs.vh"
module cursor_y_split_line_compare (
   input wire clk,
   input wire rst_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [15:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output wire pslverr,
   output reg [31:0] prdata,
   input wire lineStart,
   input wire frameStart,
   input wire [31:0] pendingStartOffset,
   output reg [10:0] scanline_q,
   output reg cursorActive_q,
   output reg [4:0] cursorRow_q,
   output reg fetchRestart_q,
   output reg [31:0] activeStartOffset_q,
   output reg startOffsetLoad_q
);

   // ************************************************************
   // apb slave
   // ************************************************************
   reg [9:0] cursorY_q;
   reg [4:0] rowSkip_q;
   reg [10:0] splitLine_q;
   reg [2:0] control_q;
   reg [31:0] readData;
   reg mapped;
   wire access;
   wire writeEn;

   assign pready = 1'b1;
   assign access = psel && penable;
   assign writeEn = access && pwrite;
   assign pslverr = access && !mapped;

   always @* begin
      readData = 32'h0000_0000;
      mapped = 1'b1;
      case (paddr)
         `CURSOR_VERTICAL_POSITION_OFS: begin
            readData[`ROW_SKIP_MSB:`ROW_SKIP_LSB] = rowSkip_q;
            readData[`CURSOR_Y_MSB:`CURSOR_Y_LSB] = cursorY_q;
         end
         `SPLIT_SCREEN_LINE_THRESHOLD_OFS: begin
            readData[`SPLIT_LINE_MSB:`SPLIT_LINE_LSB] = splitLine_q;
         end
         `SCANLINE_STATUS_OFS: begin
            readData[10:0] = scanline_q;
         end
         `SPLIT_CONTROL_OFS: begin
            readData[2:0] = control_q;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cursorY_q <= 10'h000;
         rowSkip_q <= 5'h00;
         splitLine_q <= `SPLIT_THRESHOLD_RESET;
         control_q <= `SPLIT_CONTROL_RESET;
         prdata <= 32'h0000_0000;
      end else begin
         if (psel && !penable && !pwrite) begin
            prdata <= readData;
         end
         if (writeEn) begin
            case (paddr)
               `CURSOR_VERTICAL_POSITION_OFS: begin
                  rowSkip_q <= pwdata[`ROW_SKIP_MSB:`ROW_SKIP_LSB];
                  // bit 10 and the upper half are dropped
                  cursorY_q <= pwdata[`CURSOR_Y_MSB:`CURSOR_Y_LSB];
               end
               `SPLIT_SCREEN_LINE_THRESHOLD_OFS: begin
                  splitLine_q <= pwdata[`SPLIT_LINE_MSB:`SPLIT_LINE_LSB];
               end
               `SPLIT_CONTROL_OFS: begin
                  control_q <= pwdata[2:0];
               end
               default: begin
               end
            endcase
         end
      end
   end

   // ************************************************************
   // scanline counter
   // ************************************************************
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scanline_q <= 11'h000;
      end else if (frameStart) begin
         scanline_q <= 11'h000;
      end else if (lineStart) begin
         scanline_q <= scanline_q + 11'h001;
      end
   end

   // ************************************************************
   // line compares
   // ************************************************************
   wire splitHit;
   wire cursorHit;
   wire [10:0] cursorTarget;

   assign cursorTarget = {1'b0, cursorY_q};

   line_match #(.WIDTH(`LINE_WIDTH)) splitCmp (
      .clk(clk),
      .rst_n(rst_n),
      .lineCount(scanline_q),
      .target(splitLine_q),
      .lineStart(lineStart),
      .hit_q(splitHit)
   );

   line_match #(.WIDTH(`LINE_WIDTH)) cursorCmp (
      .clk(clk),
      .rst_n(rst_n),
      .lineCount(scanline_q),
      .target(cursorTarget),
      .lineStart(lineStart),
      .hit_q(cursorHit)
   );

   // ************************************************************
   // split-screen fetch restart
   // ************************************************************
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fetchRestart_q <= 1'b0;
      end else begin
         // the fetcher zeroes its address on this pulse and keeps counting
         fetchRestart_q <= splitHit && control_q[`SPLIT_ENABLE_BIT];
      end
   end

   // ************************************************************
   // start offset taken at the cursor line
   // ************************************************************
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         activeStartOffset_q <= 32'h0000_0000;
         startOffsetLoad_q <= 1'b0;
      end else begin
         // legacy code changes the offset mid-frame; the cursor should be
         // off meanwhile since both uses share one coordinate
         startOffsetLoad_q <= cursorHit && control_q[`OFFSET_LATCH_BIT];
         if (cursorHit && control_q[`OFFSET_LATCH_BIT]) begin
            activeStartOffset_q <= pendingStartOffset;
         end
      end
   end

   // ************************************************************
   // cursor vertical window
   // ************************************************************
   reg [5:0] rowsLeft_q;
   wire [5:0] shownRows;

   // skipping rows shortens the visible height; cursorRow_q is loaded
   // with rowSkip_q at the cursor line, so it starts at the first shown row
   assign shownRows = `CURSOR_HEIGHT - {1'b0, rowSkip_q};

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rowsLeft_q <= 6'h00;
         cursorActive_q <= 1'b0;
         cursorRow_q <= 5'h00;
      end else if (frameStart || !control_q[`CURSOR_ENABLE_BIT]) begin
         rowsLeft_q <= 6'h00;
         cursorActive_q <= 1'b0;
         cursorRow_q <= 5'h00;
      end else if (cursorHit) begin
         rowsLeft_q <= shownRows - 6'h01;
         cursorActive_q <= 1'b1;
         cursorRow_q <= rowSkip_q;
      end else if (lineStart && cursorActive_q) begin
         if (rowsLeft_q == 6'h00) begin
            cursorActive_q <= 1'b0;
         end else begin
            rowsLeft_q <= rowsLeft_q - 6'h01;
            cursorRow_q <= cursorRow_q + 5'h01;
         end
      end
   end

endmodule

// ==== core/cursor_y_split_regs.vh ====
// register offsets, field positions and reset values for the vertical block
`ifndef CURSOR_Y_SPLIT_REGS_VH
`define CURSOR_Y_SPLIT_REGS_VH

// ************************************************************
// register byte offsets within the block window
// ************************************************************
`define CURSOR_VERTICAL_POSITION_OFS 16'h8358
`define SPLIT_SCREEN_LINE_THRESHOLD_OFS 16'h835c
`define SCANLINE_STATUS_OFS 16'h8354
`define SPLIT_CONTROL_OFS 16'h8360

// ************************************************************
// field positions
// ************************************************************
`define ROW_SKIP_MSB 15
`define ROW_SKIP_LSB 11
`define CURSOR_Y_MSB 9
`define CURSOR_Y_LSB 0
`define SPLIT_LINE_MSB 10
`define SPLIT_LINE_LSB 0
`define SPLIT_ENABLE_BIT 0
`define CURSOR_ENABLE_BIT 1
`define OFFSET_LATCH_BIT 2

// ************************************************************
// reset values and sizes
// ************************************************************
`define CURSOR_VERTICAL_RESET 32'h0000_0000
`define SPLIT_THRESHOLD_RESET 11'h000
`define SPLIT_CONTROL_RESET 3'h0
`define CURSOR_HEIGHT 6'h20
`define LINE_WIDTH 11

`endif

// ==== core/line_match.v ====
// one equality comparator between the scanline counter and a target line
`timescale 1ns/10ps
module line_match #(
   parameter WIDTH = 11
) (
   input wire clk,
   input wire rst_n,
   input wire [WIDTH-1:0] lineCount,
   input wire [WIDTH-1:0] target,
   input wire lineStart,
   output reg hit_q
);
   // registered so the hit lines up with the first pixel of the line
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hit_q <= 1'b0;
      end else begin
         hit_q <= lineStart && (lineCount == target);
      end
   end
endmodule

// ==== verification/cursor_y_split_line_compare_properties.sv ====
// port checker for the cursor vertical and split-line compare block
`timescale 1ns/10ps
module cursor_y_split_line_compare_checker (
   input wire clk,
   input wire rst_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [15:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   input wire pslverr,
   input wire [31:0] prdata,
   input wire lineStart,
   input wire frameStart,
   input wire [31:0] pendingStartOffset,
   input wire [10:0] scanline_q,
   input wire cursorActive_q,
   input wire [4:0] cursorRow_q,
   input wire fetchRestart_q,
   input wire [31:0] activeStartOffset_q,
   input wire startOffsetLoad_q
);
   // shadow copies of the registers, snooped from completed writes
   reg [10:0] thr_q;
   reg [4:0] skip_q;
   reg en_q;
   wire acc = psel && penable;
   wire rd = acc && !pwrite;
   wire mapped = paddr == 16'h8354 || paddr == 16'h8358 ||
      paddr == 16'h835c || paddr == 16'h8360;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         thr_q <= 11'h000;
         skip_q <= 5'h00;
         en_q <= 1'b0;
      end else if (acc && pwrite) begin
         if (paddr == 16'h835c) thr_q <= pwdata[10:0];
         if (paddr == 16'h8358) skip_q <= pwdata[15:11];
         if (paddr == 16'h8360) en_q <= pwdata[0];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence splitHit;
      lineStart && !frameStart && en_q && scanline_q == thr_q;
   endsequence
   chk_split_restart: assert property (splitHit |=> ##1 fetchRestart_q)
      else $error("fetch restart missing");
   chk_split_gated: assert property (fetchRestart_q |->
      $past(en_q) && $past(lineStart, 2)) else $error("stray restart");
   chk_scan_step: assert property (lineStart && !frameStart |=>
      scanline_q == $past(scanline_q) + 11'h001) else $error("line step");
   chk_scan_zero: assert property (frameStart |=> scanline_q == 11'h000)
      else $error("frame zero");
   chk_thr_rsvd: assert property (rd && paddr == 16'h835c |->
      prdata[31:11] == 21'h00_0000) else $error("threshold reserved");
   chk_cy_rsvd: assert property (rd && paddr == 16'h8358 |->
      prdata[31:16] == 16'h0000 && !prdata[10]) else $error("cursor reserved");
   chk_bad_addr: assert property (acc && !mapped |->
      pslverr && (pwrite || prdata == 32'h0000_0000)) else $error("unmapped");
   chk_load_cause: assert property (startOffsetLoad_q |->
      $past(lineStart, 2)) else $error("stray offset load");
   chk_cursor_row: assert property ($rose(cursorActive_q) |->
      cursorRow_q == skip_q && $past(lineStart, 2)) else $error("cursor row");
endmodule
bind cursor_y_split_line_compare cursor_y_split_line_compare_checker
   cursor_y_split_line_compare_checker_i (.clk, .rst_n, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata, .lineStart,
   .frameStart, .pendingStartOffset, .scanline_q, .cursorActive_q,
   .cursorRow_q, .fetchRestart_q, .activeStartOffset_q, .startOffsetLoad_q);

// ==== verification/test_cursor_y_split_line_compare.sv ====
// self-checking bench for the cursor vertical and split-line block
`timescale 1ns/10ps
module test_cursor_y_split_line_compare;
   logic clk, rst_n, psel, penable, pwrite, lineStart, frameStart, err;
   logic [15:0] paddr;
   logic [31:0] pwdata, pendingStartOffset, d, rd;
   wire pready, pslverr, fetchRestart_q, startOffsetLoad_q, cursorActive_q;
   wire [31:0] prdata, activeStartOffset_q;
   int seed, checks, miscompares, nRst, nLd, nAct, t, s;
   cursor_y_split_line_compare cursor_y_split_line_compare_i (.clk, .rst_n,
      .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
      .lineStart, .frameStart, .pendingStartOffset, .scanline_q(),
      .cursorActive_q, .cursorRow_q(), .fetchRestart_q, .activeStartOffset_q,
      .startOffsetLoad_q);
   always #12.5 clk = ~clk;
   // pulses are counted mid-cycle, away from the launching edge
   always @(negedge clk) begin
      nRst += fetchRestart_q;
      nLd += startOffsetLoad_q;
      if (lineStart) nAct += cursorActive_q;
   end
   // rows left on screen once the top rows of the pattern are skipped
   function int shownLines(input int skip);
      return 32 - skip;
   endfunction
   task close_out;
      if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input logic [32:0] seen, input logic [32:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task apb(input logic w, input logic [15:0] a, input logic [31:0] v);
      int k;
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, v};
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k == 50) begin
         miscompares++;
         close_out;
      end
   endtask
   task lines(input int n);
      repeat (n) begin
         @(posedge clk) lineStart <= 1'b1;
         @(posedge clk) lineStart <= 1'b0;
         repeat (3) @(posedge clk);
      end
   endtask
   task frame;
      @(posedge clk) frameStart <= 1'b1;
      @(posedge clk) frameStart <= 1'b0;
   endtask
   initial begin
      seed = 32'hb6b592ec;
      {clk, rst_n, psel, penable, pwrite, lineStart, frameStart} = 7'h00;
      {paddr, pwdata, pendingStartOffset} = 80'h0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) begin
         d = $random(seed);
         apb(1, 16'h8358, d);
         apb(0, 16'h8358, 0);
         chk(rd, d & 32'h0000_fbff);
         apb(1, 16'h835c, d);
         apb(0, 16'h835c, 0);
         chk(rd, d & 32'h0000_07ff);
      end
      apb(0, 16'h8364, 0);
      chk({err, rd}, 33'h1_0000_0000);
      t = {$random(seed)} % 8 + 3;
      for (int e = 1; e >= 0; e--) begin
         apb(1, 16'h835c, t);
         apb(1, 16'h8360, e);
         frame;
         nRst = 0;
         lines(t + 4);
         chk(nRst, e);
         apb(0, 16'h8354, 0);
         chk(rd, t + 4);
      end
      for (int i = 0; i < 3; i++) begin
         s = i == 0 ? 0 : i == 1 ? 31 : {$random(seed)} % 32;
         apb(1, 16'h8358, {16'h0000, s[4:0], 11'h002});
         apb(1, 16'h8360, 2);
         frame;
         nAct = 0;
         lines(40);
         chk(nAct, shownLines(s));
      end
      pendingStartOffset <= $random(seed);
      apb(1, 16'h8358, 5);
      apb(1, 16'h8360, 4);
      frame;
      nLd = 0;
      lines(8);
      chk(nLd, 1);
      chk(activeStartOffset_q, pendingStartOffset);
      close_out;
   end
endmodule
